// [rtl/startup_timer.sv]
// start-up timer: counts after power-on reset and after each power-down exit,
// then raises the clock-ready flag.
// assumes power_down comes from logic on sys_clk, so it needs no synchroniser.
`timescale 1ns/1ps
`default_nettype none

module startup_timer #(
  parameter int STARTUP_CYCLES = 75000
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // power state
  input wire logic power_down,
  // status
  output logic clock_ready_flag_q
);

  localparam int CW = $clog2(STARTUP_CYCLES + 1);

  initial begin
    if (STARTUP_CYCLES < 2) $error("startup_timer: STARTUP_CYCLES must be at least 2");
  end

  logic pd_q;
  logic [CW-1:0] cnt_q;
  logic wake;
  logic expire;

  assign wake = pd_q && !power_down;
  // counting pauses while powered down, the oscillator is treated as stopped
  assign expire = !clock_ready_flag_q && !power_down && (cnt_q == CW'(STARTUP_CYCLES - 1));

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pd_q <= 1'b0;
    end else begin
      pd_q <= power_down;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
    end else if (wake) begin
      cnt_q <= '0;
    end else if (!clock_ready_flag_q && !power_down) begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      clock_ready_flag_q <= 1'b0;
    end else if (wake) begin
      clock_ready_flag_q <= 1'b0;
    end else if (expire) begin
      clock_ready_flag_q <= 1'b1;
    end
  end

  a_ready_on_expiry: assert property (@(posedge sys_clk) disable iff (!rstn)
    (!clock_ready_flag_q && !power_down && !wake && cnt_q == CW'(STARTUP_CYCLES - 1)) |=> clock_ready_flag_q)
    else $error("ready flag not set on timer expiry");

  a_wake_clears_ready: assert property (@(posedge sys_clk) disable iff (!rstn)
    $fell(power_down) |-> ##1 (!clock_ready_flag_q && cnt_q == '0))
    else $error("power-down exit did not restart the timer");

  a_no_early_ready: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(clock_ready_flag_q) |-> $past(cnt_q) == CW'(STARTUP_CYCLES - 1))
    else $error("ready flag set before full start-up count");

endmodule : startup_timer

`default_nettype wire

// [rtl/clock_output.sv]
// clock output block: constants package and the top module driving the clock
// output pin through a glitch-free prescaler.
// assumes sys_clk runs at 250 MHz, ten times the 25 MHz main clock, and that the serial bus logic presents
// register writes as a one-cycle strobe on sys_clk.
//
// Function
// - main clock comes from the 25 MHz oscillator input, crystal or external source
// - start-up timer expires only after 7500 oscillator cycles from reset or wake
// - register reads and writes keep working while the start-up timer counts
// - timer expiry sets the clock-ready flag
// - clock output pin held low from power-up until the timer expires
// - first expiry starts the output at default divide by 4, 6.25 MHz
// - software or pin reset leaves select register and running output alone
// - output runs through power-down; wake restarts timer without stopping output
// - select code 000 disables the output and drives the pin low
// - no high or low phase shorter than the selected frequency implies
// - frequency change pauses output low for two to eight oscillator periods
// - select bits 2-0: 001 div1, 010 div2, 011 div3, 100 div4, 101 div8
// - select register bits 7-3 read as zero

package clock_output_pkg;
  localparam int SYS_MHZ = 250;
  localparam int OSC_MHZ = 25;
  localparam int SYS_PER_OSC = SYS_MHZ / OSC_MHZ;
  localparam int STARTUP_OSC_CYCLES = 7500;
  localparam int STARTUP_SYS_CYCLES = STARTUP_OSC_CYCLES * SYS_PER_OSC;
  localparam int GAP_OSC_PERIODS = 4;
  localparam int GAP_CYCLES = GAP_OSC_PERIODS * SYS_PER_OSC;
  localparam int CNT_W = 7;
  localparam int REG_W = 8;
  localparam int SEL_W = 3;
  localparam int SEL_LSB = 0;
  localparam logic [7:0] SELECT_RESET = 8'h04;
  localparam logic [2:0] CODE_OFF = 3'h0;
  localparam logic [2:0] CODE_DIV1 = 3'h1;
  localparam logic [2:0] CODE_DIV2 = 3'h2;
  localparam logic [2:0] CODE_DIV3 = 3'h3;
  localparam logic [2:0] CODE_DIV4 = 3'h4;
  localparam logic [2:0] CODE_DIV8 = 3'h5;
  typedef enum logic [1:0] {S_IDLE, S_GAP, S_HIGH, S_LOW} clk_state_t;
endpackage : clock_output_pkg

`timescale 1ns/1ps
`default_nettype none

module clock_output #(
  parameter int STARTUP_CYCLES = clock_output_pkg::STARTUP_SYS_CYCLES
) (
  // clock and power-on reset
  input wire logic sys_clk,
  input wire logic rstn,
  // power state from the power controller
  input wire logic power_down,
  // select register access from the serial bus logic
  input wire logic select_wr_en,
  input wire logic [7:0] select_wr_data,
  output logic [7:0] clock_output_select_q,
  // status
  output logic clock_ready_flag_q,
  // pin
  output logic clock_output_pin_q
);

  initial begin
    if (STARTUP_CYCLES < 2) $error("clock_output: STARTUP_CYCLES must be at least 2");
  end

  // half period in sys_clk cycles; zero marks off and the reserved codes
  function automatic logic [clock_output_pkg::CNT_W-1:0] half_len(input logic [2:0] code);
    int d;
    d = 0;
    unique case (code)
      clock_output_pkg::CODE_DIV1: d = 1;
      clock_output_pkg::CODE_DIV2: d = 2;
      clock_output_pkg::CODE_DIV3: d = 3;
      clock_output_pkg::CODE_DIV4: d = 4;
      clock_output_pkg::CODE_DIV8: d = 8;
      default: d = 0;
    endcase
    return clock_output_pkg::CNT_W'(d * clock_output_pkg::SYS_PER_OSC / 2);
  endfunction : half_len

  localparam logic [clock_output_pkg::CNT_W-1:0] GAP_LOAD = clock_output_pkg::CNT_W'(clock_output_pkg::GAP_CYCLES - 1);
  localparam logic [clock_output_pkg::CNT_W-1:0] ONE = clock_output_pkg::CNT_W'(1);

  clock_output_pkg::clk_state_t state_q;
  logic [clock_output_pkg::CNT_W-1:0] cnt_q;
  logic [2:0] cur_q;
  logic started_q;
  logic [2:0] sel;
  logic [clock_output_pkg::CNT_W-1:0] half_cur;
  logic [clock_output_pkg::CNT_W-1:0] half_sel;

  assign sel = clock_output_select_q[clock_output_pkg::SEL_LSB +: clock_output_pkg::SEL_W];
  assign half_cur = half_len(cur_q);
  assign half_sel = half_len(sel);

  startup_timer #(
    .STARTUP_CYCLES(STARTUP_CYCLES)
  ) u_timer (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .power_down(power_down),
    .clock_ready_flag_q(clock_ready_flag_q)
  );

  // only power-on reset touches the select register; soft and pin resets
  // are kept outside this block on purpose
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      clock_output_select_q <= clock_output_pkg::SELECT_RESET;
    end else if (select_wr_en) begin
      // writes are taken regardless of the ready flag
      clock_output_select_q <= {5'h00, select_wr_data[2:0]};
    end
  end

  // first expiry releases the pin for good; a later wake does not stop it
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      started_q <= 1'b0;
    end else if (clock_ready_flag_q) begin
      started_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= clock_output_pkg::S_IDLE;
      cnt_q <= '0;
      cur_q <= clock_output_pkg::CODE_OFF;
      clock_output_pin_q <= 1'b0;
    end else begin
      unique case (state_q)
        clock_output_pkg::S_IDLE: begin
          clock_output_pin_q <= 1'b0;
          if (started_q && half_sel != '0) begin
            cur_q <= sel;
            cnt_q <= GAP_LOAD;
            state_q <= clock_output_pkg::S_GAP;
          end
        end
        clock_output_pkg::S_GAP: begin
          if (cnt_q == '0) begin
            clock_output_pin_q <= 1'b1;
            cnt_q <= half_cur - ONE;
            state_q <= clock_output_pkg::S_HIGH;
          end else begin
            cnt_q <= cnt_q - ONE;
          end
        end
        clock_output_pkg::S_HIGH: begin
          if (cnt_q == '0) begin
            clock_output_pin_q <= 1'b0;
            cnt_q <= half_cur - ONE;
            state_q <= clock_output_pkg::S_LOW;
          end else begin
            cnt_q <= cnt_q - ONE;
          end
        end
        clock_output_pkg::S_LOW: begin
          if (cnt_q != '0) begin
            cnt_q <= cnt_q - ONE;
          end else if (sel == cur_q) begin
            clock_output_pin_q <= 1'b1;
            cnt_q <= half_cur - ONE;
            state_q <= clock_output_pkg::S_HIGH;
          end else if (half_sel == '0) begin
            // reserved codes fall here too, which is safer than guessing
            state_q <= clock_output_pkg::S_IDLE;
          end else begin
            cur_q <= sel;
            cnt_q <= GAP_LOAD;
            state_q <= clock_output_pkg::S_GAP;
          end
        end
      endcase
    end
  end

  // helper counters for the phase checks
  logic [7:0] hi_cnt_q;
  logic [7:0] lo_cnt_q;
  logic from_run_q;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      hi_cnt_q <= 8'h00;
      lo_cnt_q <= 8'h00;
      from_run_q <= 1'b0;
    end else begin
      hi_cnt_q <= clock_output_pin_q ? hi_cnt_q + 8'h01 : 8'h00;
      lo_cnt_q <= clock_output_pin_q ? 8'h00 : ((lo_cnt_q == 8'hff) ? lo_cnt_q : lo_cnt_q + 8'h01);
      if (state_q == clock_output_pkg::S_LOW) begin
        from_run_q <= 1'b1;
      end else if (state_q == clock_output_pkg::S_IDLE) begin
        from_run_q <= 1'b0;
      end
    end
  end

  a_low_before_ready: assert property (@(posedge sys_clk) disable iff (!rstn)
    !started_q |-> !clock_output_pin_q)
    else $error("clock output left low state before start-up expiry");

  a_high_phase_exact: assert property (@(posedge sys_clk) disable iff (!rstn)
    $fell(clock_output_pin_q) |-> hi_cnt_q == {1'b0, half_cur})
    else $error("high phase length differs from selected divider");

  a_low_phase_min: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(clock_output_pin_q) |-> lo_cnt_q >= {1'b0, half_cur})
    else $error("low phase shorter than selected divider");

  a_switch_gap_bounds: assert property (@(posedge sys_clk) disable iff (!rstn)
    ($rose(clock_output_pin_q) && $past(state_q) == clock_output_pkg::S_GAP && from_run_q)
      |-> (lo_cnt_q >= 8'd20 && lo_cnt_q <= 8'd80))
    else $error("switch pause outside two to eight oscillator periods");

  a_disable_drives_low: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_q == clock_output_pkg::S_LOW && cnt_q == '0 && sel == clock_output_pkg::CODE_OFF && !select_wr_en)
      |=> (state_q == clock_output_pkg::S_IDLE) ##1 !clock_output_pin_q [*3])
    else $error("disabled output did not settle low");

  a_default_start: assert property (@(posedge sys_clk) disable iff (!rstn)
    ($rose(started_q) && sel == clock_output_pkg::CODE_DIV4 && state_q == clock_output_pkg::S_IDLE)
      |-> ##41 (clock_output_pin_q && cur_q == clock_output_pkg::CODE_DIV4))
    else $error("default divide-by-4 output did not start");

  a_select_write: assert property (@(posedge sys_clk) disable iff (!rstn)
    select_wr_en |=> clock_output_select_q == {5'h00, $past(select_wr_data[2:0])})
    else $error("select write not stored or upper bits not zero");

  a_upper_bits_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
    clock_output_select_q[7:3] == 5'h00)
    else $error("select register upper bits not zero");

  a_runs_through_wake: assert property (@(posedge sys_clk) disable iff (!rstn)
    ($fell(power_down) && state_q != clock_output_pkg::S_IDLE && half_sel != '0)
      |=> state_q != clock_output_pkg::S_IDLE)
    else $error("power-down exit interrupted the clock output");

  a_change_at_low_end: assert property (@(posedge sys_clk) disable iff (!rstn)
    (cur_q != $past(cur_q) && $past(state_q) != clock_output_pkg::S_IDLE)
      |-> ($past(state_q) == clock_output_pkg::S_LOW && $past(cnt_q) == '0 && !clock_output_pin_q))
    else $error("divider changed outside end of low phase");

endmodule : clock_output

`default_nettype wire

// [testbench/host_model.sv]
// host controller model: runs off the clock output pin and times each
// completed high or low phase of it in sys_clk cycles.
// assumes sys_clk and rstn are shared with the device under test.
`timescale 1ns/1ps
`default_nettype none

module host_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // clock from the device
  input wire logic clock_output_pin_q,
  // measured phase
  output logic phase_done_q,
  output logic phase_level_q,
  output logic [15:0] phase_len_q,
  // host clock ticks seen
  output logic [15:0] host_ticks_q
);
  logic last_q;
  logic [15:0] run_q;

  // phase meter: a phase ends when the sampled level changes
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      last_q <= 1'b0;
      run_q <= 16'h0000;
      phase_done_q <= 1'b0;
      phase_level_q <= 1'b0;
      phase_len_q <= 16'h0000;
    end else begin
      phase_done_q <= (clock_output_pin_q != last_q);
      if (clock_output_pin_q != last_q) begin
        phase_level_q <= last_q;
        phase_len_q <= run_q;
        run_q <= 16'h0001;
      end else begin
        run_q <= run_q + 16'h0001;
      end
      last_q <= clock_output_pin_q;
    end
  end

  // the host's own logic is clocked by the pin
  always_ff @(posedge clock_output_pin_q or negedge rstn) begin
    if (!rstn) begin
      host_ticks_q <= 16'h0000;
    end else begin
      host_ticks_q <= host_ticks_q + 16'h0001;
    end
  end
endmodule : host_model

`default_nettype wire

// [testbench/tb_clock_output.sv]
// testbench for clock_output: expected phases are queued by the driver and
// compared by a monitor fed from the host model.
// assumes a short start-up count so the run stays brief.
`timescale 1ns/1ps
`default_nettype none

module tb_clock_output;
  localparam int N = 20;
  localparam int HALF = clock_output_pkg::SYS_PER_OSC / 2;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic power_down = 1'b0;
  logic select_wr_en = 1'b0;
  logic [7:0] select_wr_data = 8'h00;
  logic [7:0] clock_output_select_q;
  logic clock_ready_flag_q;
  logic clock_output_pin_q;
  logic phase_done_q;
  logic phase_level_q;
  logic [15:0] phase_len_q;
  logic [15:0] host_ticks_q;
  logic [15:0] t0;
  logic [16:0] exp_q[$];
  logic [16:0] want;
  logic [31:0] seed = 32'h0000_001a;
  logic [7:0] codes [5] = '{8'hf9, 8'h0a, 8'h33, 8'h85, 8'h04};
  int num_errors = 0;
  int comparisons = 0;
  int cur = 4;
  int n;

  always #2 sys_clk = ~sys_clk;

  clock_output #(.STARTUP_CYCLES(N)) i_dut (
    .sys_clk(sys_clk), .rstn(rstn), .power_down(power_down), .select_wr_en(select_wr_en),
    .select_wr_data(select_wr_data), .clock_output_select_q(clock_output_select_q),
    .clock_ready_flag_q(clock_ready_flag_q), .clock_output_pin_q(clock_output_pin_q)
  );
  host_model i_host (
    .sys_clk(sys_clk), .rstn(rstn), .clock_output_pin_q(clock_output_pin_q), .phase_done_q(phase_done_q),
    .phase_level_q(phase_level_q), .phase_len_q(phase_len_q), .host_ticks_q(host_ticks_q)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic timeout();
    num_errors++;
    $display("timeout at %0t", $time);
    report_and_stop();
  endtask : timeout

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift

  // half period in sys_clk cycles; code 5 divides by 8
  function automatic int half(input int code);
    return (code == 5 ? 8 : code) * HALF;
  endfunction : half

  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic note(input logic level, input int len);
    exp_q.push_back({level, 16'(len)});
  endtask : note

  task automatic wr(input logic [7:0] d);
    select_wr_en = 1'b1;
    select_wr_data = d;
    tick(1);
    select_wr_en = 1'b0;
  endtask : wr

  task automatic wait_pin(input logic v);
    for (int i = 0; i < 500; i++) begin
      if (clock_output_pin_q === v) return;
      tick(1);
    end
    timeout();
  endtask : wait_pin

  task automatic drain();
    for (int i = 0; i < 1000; i++) begin
      if (exp_q.size() == 0) return;
      tick(1);
    end
    timeout();
  endtask : drain

  task automatic wait_ready(output int k);
    k = 0;
    while (clock_ready_flag_q !== 1'b1) begin
      if (k > 200) timeout();
      tick(1);
      k++;
    end
  endtask : wait_ready

  // enter at a rising pin edge so the change lands inside a high phase
  task automatic switch_to(input logic [7:0] d);
    wait_pin(1'b0);
    wait_pin(1'b1);
    tick(2);
    note(1'b1, half(cur));
    wr(d);
    check(clock_output_select_q, {5'h00, d[2:0]});
    if (d[2:0] == 3'h0) begin
      drain();
      tick(100);
      check(clock_output_pin_q, 1'b0);
      wr(8'h04);
      cur = 4;
    end else begin
      // an unchanged code runs on with no pause
      note(1'b0, half(cur) + ((d[2:0] == cur) ? 0 : clock_output_pkg::GAP_CYCLES));
      note(1'b1, half(d[2:0]));
      note(1'b0, half(d[2:0]));
      cur = d[2:0];
      drain();
    end
  endtask : switch_to

  always @(negedge sys_clk) begin
    if (phase_done_q === 1'b1 && exp_q.size() > 0) begin
      want = exp_q.pop_front();
      check({phase_level_q, phase_len_q}, want);
    end
  end

  initial begin
    tick(20);
    check(clock_output_select_q, clock_output_pkg::SELECT_RESET);
    check(clock_ready_flag_q, 1'b0);
    rstn = 1'b1;
    wr(8'hfc);
    check(clock_output_select_q, 8'h04);
    wait_ready(n);
    check(n + 1 >= N && n + 1 <= N + 2, 1'b1);
    check(clock_output_pin_q, 1'b0);
    wait_pin(1'b1);
    tick(2);
    note(1'b1, half(4));
    note(1'b0, half(4));
    drain();
    $display("test startup done");
    foreach (codes[i]) switch_to(codes[i]);
    for (int i = 0; i < 3; i++) begin
      seed = xorshift(seed);
      switch_to({seed[7:3], 3'(seed[10:8] % 5 + 1)});
    end
    switch_to(8'h00);
    $display("test divider done");
    wait_pin(1'b0);
    wait_pin(1'b1);
    tick(2);
    note(1'b1, half(4));
    note(1'b0, half(4));
    t0 = host_ticks_q;
    power_down = 1'b1;
    tick(30);
    check(clock_ready_flag_q, 1'b1);
    power_down = 1'b0;
    tick(1);
    check(clock_ready_flag_q, 1'b0);
    wait_ready(n);
    check(n >= N - 1 && n <= N + 2, 1'b1);
    check(host_ticks_q != t0, 1'b1);
    drain();
    $display("test power_down done");
    rstn = 1'b0;
    tick(2);
    check(clock_output_select_q, 8'h04);
    check(clock_output_pin_q, 1'b0);
    $display("test second_reset done");
    report_and_stop();
  end
endmodule : tb_clock_output

`default_nettype wire
